// *** design/current_monitor_regs.svh ***
`ifndef CURRENT_MONITOR_REGS_SVH
`define CURRENT_MONITOR_REGS_SVH

// register offsets
`define LV_CURRENT_CFG_FAST_FILTER_ADDR 8'h34
`define LV_CURRENT_CFG_TRIP_ADDR 8'h35
`define HV_CURRENT_CFG_FAST_FILTER_ADDR 8'h36
`define HV_CURRENT_CFG_TRIP_ADDR 8'h37

// field positions, first byte
`define QUICK_TRIP_LEVEL_MSB 7
`define QUICK_TRIP_LEVEL_LSB 5
`define DEGLITCH_SKIP_BIT 4
`define WINDOW_COMPARE_ON_BIT 3
`define LOW_SIDE_SENSING_BIT 2

// field positions, second byte
`define FIRST_LEVEL_LSB 6
`define SECOND_LEVEL_LSB 4
`define FIRST_GAIN_LSB 2
`define SECOND_GAIN_LSB 0

// writable masks, fixed bits read zero
`define LV_FAST_FILTER_MASK 8'hFC
`define HV_FAST_FILTER_MASK 8'hF8
`define TRIP_MASK 8'hFF

// reset values
`define LV_FAST_FILTER_RESET 8'h00
`define HV_FAST_FILTER_RESET 8'h00
`define TRIP_RESET 8'h00

`endif

// *** design/current_monitor_pkg.sv ***
package current_monitor_pkg;

   // trip level in units of 0.5 mV differential
   typedef logic [9:0] trip_halfmv_t;

   typedef enum logic [1:0] {
      GAIN_100 = 2'b00,
      GAIN_50 = 2'b01,
      GAIN_25 = 2'b10,
      GAIN_10 = 2'b11
   } gain_code_e;

   typedef struct packed {
      logic [2:0] quick_trip_level;
      logic deglitch_skip;
      logic window_compare_on;
      logic low_side_sensing;
      logic [1:0] first_comparator_level;
      logic [1:0] second_comparator_level;
      logic [1:0] first_gain;
      logic [1:0] second_gain;
   } channel_cfg_s;

endpackage

// *** design/channel_cfg_if.sv ***
`timescale 1ns/10ps
interface channel_cfg_if;
   current_monitor_pkg::channel_cfg_s cfg;
   current_monitor_pkg::trip_halfmv_t first_trip;
   current_monitor_pkg::trip_halfmv_t second_trip;
   modport bank (output cfg, input first_trip, input second_trip);
   modport decode (input cfg, output first_trip, output second_trip);
endinterface

// *** design/current_trip_decode.sv ***
`timescale 1ns/10ps
module current_trip_decode (
   // settings in, trip levels out
   channel_cfg_if.decode ch
);

   function automatic current_monitor_pkg::trip_halfmv_t trip_lookup(
      input logic [1:0] level,
      input logic [1:0] gain
   );
      logic [3:0] sel;
      sel = {level, gain};
      case (sel)
         4'h0: trip_lookup = 10'h010;
         4'h1: trip_lookup = 10'h01F;
         4'h2: trip_lookup = 10'h03D;
         4'h3: trip_lookup = 10'h096;
         4'h4: trip_lookup = 10'h015;
         4'h5: trip_lookup = 10'h029;
         4'h6: trip_lookup = 10'h051;
         4'h7: trip_lookup = 10'h0C8;
         4'h8: trip_lookup = 10'h01D;
         4'h9: trip_lookup = 10'h039;
         4'hA: trip_lookup = 10'h071;
         4'hB: trip_lookup = 10'h118;
         4'hC: trip_lookup = 10'h028;
         4'hD: trip_lookup = 10'h04E;
         4'hE: trip_lookup = 10'h09A;
         4'hF: trip_lookup = 10'h17C;
         default: trip_lookup = 10'h000;
      endcase
   endfunction

   // same table for both channels, one instance each
   assign ch.first_trip = trip_lookup(ch.cfg.first_comparator_level, ch.cfg.first_gain);
   assign ch.second_trip = trip_lookup(ch.cfg.second_comparator_level, ch.cfg.second_gain);

endmodule // current_trip_decode

// *** design/current_monitor_config.sv ***
`timescale 1ns/10ps
`include "current_monitor_regs.svh"

// Functional notes
// - lv first byte: quick level 7:5, skip 4, window 3, low-side 2, 1:0 zero.
// - hv first byte same layout; bit 2 unused; bits 2:0 zero.
// - second byte: first level 7:6, second 5:4, first gain 3:2, second gain 1:0.
// - level and gain select trip voltage; same decode both channels.
// - comparator outputs deglitched unless skip bit is one.
// - window bit turns window comparison off at 0, on at 1.
// - low-side sensing only on lv channel; bit enables it.
// - trip points, filter and window writable by host over serial bus.
module current_monitor_config #(
   parameter int FILTER_DEPTH = 4
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // register port from serial host engine
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   output logic REG_HIT,
   // raw comparator outputs: [0] first, [1] second
   input wire logic [1:0] LV_CMP_RAW,
   input wire logic [1:0] HV_CMP_RAW,
   // filtered comparator outputs
   output logic [1:0] LV_CMP,
   output logic [1:0] HV_CMP,
   // settings to analog front end
   output logic [2:0] LV_QUICK_TRIP_LEVEL,
   output logic [2:0] HV_QUICK_TRIP_LEVEL,
   output logic LV_WINDOW_COMPARE_ON,
   output logic HV_WINDOW_COMPARE_ON,
   output logic LV_LOW_SIDE_SENSING,
   output logic [9:0] LV_FIRST_TRIP,
   output logic [9:0] LV_SECOND_TRIP,
   output logic [9:0] HV_FIRST_TRIP,
   output logic [9:0] HV_SECOND_TRIP
);

   localparam int CW = $clog2(FILTER_DEPTH + 1);

   logic [7:0] lv_current_cfg_fast_filter;
   logic [7:0] lv_current_cfg_trip;
   logic [7:0] hv_current_cfg_fast_filter;
   logic [7:0] hv_current_cfg_trip;
   logic [7:0] next_rdata;
   logic hit;

   channel_cfg_if lv_ch ();
   channel_cfg_if hv_ch ();

   function automatic current_monitor_pkg::channel_cfg_s unpack_cfg(
      input logic [7:0] b0,
      input logic [7:0] b1
   );
      current_monitor_pkg::channel_cfg_s c;
      c.quick_trip_level = b0[`QUICK_TRIP_LEVEL_MSB:`QUICK_TRIP_LEVEL_LSB];
      c.deglitch_skip = b0[`DEGLITCH_SKIP_BIT];
      c.window_compare_on = b0[`WINDOW_COMPARE_ON_BIT];
      c.low_side_sensing = b0[`LOW_SIDE_SENSING_BIT];
      c.first_comparator_level = b1[`FIRST_LEVEL_LSB +: 2];
      c.second_comparator_level = b1[`SECOND_LEVEL_LSB +: 2];
      c.first_gain = b1[`FIRST_GAIN_LSB +: 2];
      c.second_gain = b1[`SECOND_GAIN_LSB +: 2];
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // register writes

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         lv_current_cfg_fast_filter <= `LV_FAST_FILTER_RESET;
         lv_current_cfg_trip <= `TRIP_RESET;
         hv_current_cfg_fast_filter <= `HV_FAST_FILTER_RESET;
         hv_current_cfg_trip <= `TRIP_RESET;
      end else if (REG_WR) begin
         case (REG_ADDR)
            `LV_CURRENT_CFG_FAST_FILTER_ADDR: begin
               lv_current_cfg_fast_filter <= REG_WDATA & `LV_FAST_FILTER_MASK;
            end
            `LV_CURRENT_CFG_TRIP_ADDR: begin
               lv_current_cfg_trip <= REG_WDATA & `TRIP_MASK;
            end
            `HV_CURRENT_CFG_FAST_FILTER_ADDR: begin
               hv_current_cfg_fast_filter <= REG_WDATA & `HV_FAST_FILTER_MASK;
            end
            `HV_CURRENT_CFG_TRIP_ADDR: begin
               hv_current_cfg_trip <= REG_WDATA & `TRIP_MASK;
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register reads

   always_comb begin
      hit = 1'b1;
      case (REG_ADDR)
         `LV_CURRENT_CFG_FAST_FILTER_ADDR: next_rdata = lv_current_cfg_fast_filter;
         `LV_CURRENT_CFG_TRIP_ADDR: next_rdata = lv_current_cfg_trip;
         `HV_CURRENT_CFG_FAST_FILTER_ADDR: next_rdata = hv_current_cfg_fast_filter;
         `HV_CURRENT_CFG_TRIP_ADDR: next_rdata = hv_current_cfg_trip;
         default: begin
            next_rdata = 8'h00;
            hit = 1'b0;
         end
      endcase
   end

   // read data held until next read so the host engine can shift it out
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         REG_RDATA <= 8'h00;
      end else if (REG_RD) begin
         REG_RDATA <= next_rdata;
      end
   end

   assign REG_HIT = hit;

   ////////////////////////////////////////////////////////////////////////////
   // decoded settings

   assign lv_ch.cfg = unpack_cfg(lv_current_cfg_fast_filter, lv_current_cfg_trip);
   assign hv_ch.cfg = unpack_cfg(hv_current_cfg_fast_filter, hv_current_cfg_trip);

   current_trip_decode u_lv_decode (
      .ch(lv_ch.decode)
   );

   current_trip_decode u_hv_decode (
      .ch(hv_ch.decode)
   );

   assign LV_FIRST_TRIP = lv_ch.first_trip;
   assign LV_SECOND_TRIP = lv_ch.second_trip;
   assign HV_FIRST_TRIP = hv_ch.first_trip;
   assign HV_SECOND_TRIP = hv_ch.second_trip;
   assign LV_QUICK_TRIP_LEVEL = lv_ch.cfg.quick_trip_level;
   assign HV_QUICK_TRIP_LEVEL = hv_ch.cfg.quick_trip_level;
   assign LV_WINDOW_COMPARE_ON = lv_ch.cfg.window_compare_on;
   assign HV_WINDOW_COMPARE_ON = hv_ch.cfg.window_compare_on;
   assign LV_LOW_SIDE_SENSING = lv_ch.cfg.low_side_sensing;

   ////////////////////////////////////////////////////////////////////////////
   // glitch filters: output follows input only after FILTER_DEPTH stable cycles

   logic [1:0] raw [2];
   logic [1:0] skip;
   logic [1:0] filt [2];
   logic [CW-1:0] cnt [2][2];

   assign raw[0] = LV_CMP_RAW;
   assign raw[1] = HV_CMP_RAW;
   assign skip[0] = lv_ch.cfg.deglitch_skip;
   assign skip[1] = hv_ch.cfg.deglitch_skip;

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         for (int c = 0; c < 2; c++) begin
            filt[c] <= 2'b00;
            for (int k = 0; k < 2; k++) begin
               cnt[c][k] <= '0;
            end
         end
      end else begin
         for (int c = 0; c < 2; c++) begin
            for (int k = 0; k < 2; k++) begin
               if (raw[c][k] == filt[c][k]) begin
                  cnt[c][k] <= '0;
               end else if (cnt[c][k] == CW'(FILTER_DEPTH - 1)) begin
                  filt[c][k] <= raw[c][k];
                  cnt[c][k] <= '0;
               end else begin
                  cnt[c][k] <= cnt[c][k] + 1'b1;
               end
            end
         end
      end
   end

   // bypass is combinational so a skipped filter adds no latency
   assign LV_CMP = skip[0] ? raw[0] : filt[0];
   assign HV_CMP = skip[1] ? raw[1] : filt[1];

   ////////////////////////////////////////////////////////////////////////////
   // checks

   a_hv_unused_zero: assert property (@(posedge CLK) disable iff (!RST_B)
      hv_current_cfg_fast_filter[2:0] == 3'b000)
      else $error("hv fixed bits not zero");

   a_lv_fixed_zero: assert property (@(posedge CLK) disable iff (!RST_B)
      lv_current_cfg_fast_filter[1:0] == 2'b00)
      else $error("lv fixed bits not zero");

   a_write_trip_lands: assert property (@(posedge CLK) disable iff (!RST_B)
      (REG_WR && REG_ADDR == `LV_CURRENT_CFG_TRIP_ADDR)
      |=> lv_current_cfg_trip == $past(REG_WDATA))
      else $error("lv trip write lost");

   a_window_follow: assert property (@(posedge CLK) disable iff (!RST_B)
      (REG_WR && REG_ADDR == `HV_CURRENT_CFG_FAST_FILTER_ADDR)
      |=> HV_WINDOW_COMPARE_ON == $past(REG_WDATA[3]))
      else $error("hv window bit not applied");

   a_low_side_write: assert property (@(posedge CLK) disable iff (!RST_B)
      (REG_WR && REG_ADDR == `LV_CURRENT_CFG_FAST_FILTER_ADDR)
      |=> LV_LOW_SIDE_SENSING == $past(REG_WDATA[2]))
      else $error("low side bit not applied");

   a_trip_corner: assert property (@(posedge CLK) disable iff (!RST_B)
      (lv_current_cfg_trip[7:6] == 2'b11 && lv_current_cfg_trip[3:2] == 2'b11)
      |-> LV_FIRST_TRIP == 10'h17C)
      else $error("190 mV corner wrong");

   a_bypass_direct: assert property (@(posedge CLK) disable iff (!RST_B)
      skip[0] |-> LV_CMP == LV_CMP_RAW)
      else $error("bypass not direct");

   a_filter_holds: assert property (@(posedge CLK) disable iff (!RST_B)
      (!skip[1] && $changed(HV_CMP_RAW[0]) && HV_CMP_RAW[0] != filt[1][0])
      |=> HV_CMP[0] == $past(HV_CMP[0]) || skip[1])
      else $error("glitch passed filter");

   a_read_unmapped: assert property (@(posedge CLK) disable iff (!RST_B)
      (REG_RD && !hit) |=> REG_RDATA == 8'h00)
      else $error("unmapped read not zero");

   // write, read, decode and filter checks

   a_lv_first_lands: assert property (@(posedge CLK) disable iff (!RST_B)
      (REG_WR && REG_ADDR == `LV_CURRENT_CFG_FAST_FILTER_ADDR)
      |=> lv_current_cfg_fast_filter == ($past(REG_WDATA) & `LV_FAST_FILTER_MASK))
      else $error("lv first byte write lost");

   a_hv_first_lands: assert property (@(posedge CLK) disable iff (!RST_B)
      (REG_WR && REG_ADDR == `HV_CURRENT_CFG_FAST_FILTER_ADDR)
      |=> hv_current_cfg_fast_filter == ($past(REG_WDATA) & `HV_FAST_FILTER_MASK))
      else $error("hv first byte write lost");

   a_hv_trip_lands: assert property (@(posedge CLK) disable iff (!RST_B)
      (REG_WR && REG_ADDR == `HV_CURRENT_CFG_TRIP_ADDR)
      |=> hv_current_cfg_trip == $past(REG_WDATA))
      else $error("hv trip write lost");

   a_lv_window_follow: assert property (@(posedge CLK) disable iff (!RST_B)
      (REG_WR && REG_ADDR == `LV_CURRENT_CFG_FAST_FILTER_ADDR)
      |=> LV_WINDOW_COMPARE_ON == $past(REG_WDATA[`WINDOW_COMPARE_ON_BIT]))
      else $error("lv window bit not applied");

   a_skip_follow: assert property (@(posedge CLK) disable iff (!RST_B)
      (REG_WR && REG_ADDR == `LV_CURRENT_CFG_FAST_FILTER_ADDR)
      |=> skip[0] == $past(REG_WDATA[`DEGLITCH_SKIP_BIT]))
      else $error("lv skip bit not applied");

   a_quick_level_follow: assert property (@(posedge CLK) disable iff (!RST_B)
      (REG_WR && REG_ADDR == `HV_CURRENT_CFG_FAST_FILTER_ADDR)
      |=> HV_QUICK_TRIP_LEVEL == $past(REG_WDATA[`QUICK_TRIP_LEVEL_MSB:`QUICK_TRIP_LEVEL_LSB]))
      else $error("hv quick level not applied");

   a_no_stray_write: assert property (@(posedge CLK) disable iff (!RST_B)
      !(REG_WR && hit) |=> $stable(lv_current_cfg_fast_filter) && $stable(lv_current_cfg_trip)
         && $stable(hv_current_cfg_fast_filter) && $stable(hv_current_cfg_trip))
      else $error("register changed without a mapped write");

   a_read_hv_first: assert property (@(posedge CLK) disable iff (!RST_B)
      (REG_RD && REG_ADDR == `HV_CURRENT_CFG_FAST_FILTER_ADDR)
      |=> REG_RDATA == $past(hv_current_cfg_fast_filter) && REG_RDATA[2:0] == 3'b000)
      else $error("hv first byte read wrong");

   a_rdata_holds: assert property (@(posedge CLK) disable iff (!RST_B)
      !REG_RD |=> $stable(REG_RDATA))
      else $error("read data moved without a read");

   a_filter_settles: assert property (@(posedge CLK) disable iff (!RST_B)
      $changed(filt[0][0]) |-> $past(cnt[0][0]) == CW'(FILTER_DEPTH - 1))
      else $error("filter output moved early");

   a_trip_floor: assert property (@(posedge CLK) disable iff (!RST_B)
      (lv_current_cfg_trip[7:6] == 2'b00 && lv_current_cfg_trip[3:2] == 2'b00)
      |-> LV_FIRST_TRIP == 10'h010)
      else $error("8 mV corner wrong");

   a_hv_trip_corner: assert property (@(posedge CLK) disable iff (!RST_B)
      (hv_current_cfg_trip[5:4] == 2'b11 && hv_current_cfg_trip[1:0] == 2'b11)
      |-> HV_SECOND_TRIP == 10'h17C)
      else $error("hv second 190 mV corner wrong");

   a_lv_second_trip: assert property (@(posedge CLK) disable iff (!RST_B)
      (lv_current_cfg_trip[5:4] == 2'b01 && lv_current_cfg_trip[1:0] == 2'b10)
      |-> LV_SECOND_TRIP == 10'h051)
      else $error("lv second trip decode wrong");

   a_hit_decode: assert property (@(posedge CLK) disable iff (!RST_B)
      hit == (REG_ADDR >= `LV_CURRENT_CFG_FAST_FILTER_ADDR && REG_ADDR <= `HV_CURRENT_CFG_TRIP_ADDR))
      else $error("address hit decode wrong");

endmodule // current_monitor_config

// *** test/reg_host_model.sv ***
`timescale 1ns/10ps
module reg_host_model (
   // clock
   input wire logic CLK,
   // register port
   output logic [7:0] REG_ADDR,
   output logic [7:0] REG_WDATA,
   output logic REG_WR,
   output logic REG_RD,
   input wire logic [7:0] REG_RDATA
);
   initial begin
      REG_ADDR = 8'h00;
      REG_WDATA = 8'h00;
      REG_WR = 1'b0;
      REG_RD = 1'b0;
   end

   ////////////////////////////////////////////////////////////////
   // one-cycle strobes, everything held through the taking edge
   task automatic write(input logic [7:0] addr, input logic [7:0] data);
      @(posedge CLK);
      #2;
      REG_ADDR = addr;
      REG_WDATA = data;
      REG_WR = 1'b1;
      @(posedge CLK);
      #2;
      REG_WR = 1'b0;
      // stale data must not look like the last write
      REG_WDATA = ~data;
   endtask

   task automatic read(input logic [7:0] addr, output logic [7:0] data);
      @(posedge CLK);
      #2;
      REG_ADDR = addr;
      REG_RD = 1'b1;
      @(posedge CLK);
      #2;
      REG_RD = 1'b0;
      data = REG_RDATA;
   endtask
endmodule // reg_host_model

// *** test/current_monitor_config_tb.sv ***
`timescale 1ns/10ps
module current_monitor_config_tb;
   localparam int FD = 2;
   // half-millivolt codes indexed by {gain, level}
   localparam logic [9:0] trip_tbl [16] = '{10'h010, 10'h015, 10'h01D, 10'h028,
      10'h01F, 10'h029, 10'h039, 10'h04E, 10'h03D, 10'h051, 10'h071, 10'h09A,
      10'h096, 10'h0C8, 10'h118, 10'h17C};
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
   logic reg_wr, reg_rd, reg_hit, lv_ws, hv_ws, lv_ls;
   logic [1:0] lv_raw = 2'b00;
   logic [1:0] hv_raw = 2'b00;
   logic [1:0] lv_cmp, hv_cmp, l, g;
   logic [2:0] lv_qt, hv_qt;
   logic [9:0] lv_ft, lv_st, hv_ft, hv_st;
   int num_errors = 0;
   int n_compared = 0;

   always #25 clk = ~clk;

   reg_host_model host_u (.CLK(clk), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata));

   current_monitor_config #(.FILTER_DEPTH(FD)) dut_u (.CLK(clk), .RST_B(rst_b),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_RDATA(reg_rdata), .REG_HIT(reg_hit), .LV_CMP_RAW(lv_raw), .HV_CMP_RAW(hv_raw),
      .LV_CMP(lv_cmp), .HV_CMP(hv_cmp), .LV_QUICK_TRIP_LEVEL(lv_qt),
      .HV_QUICK_TRIP_LEVEL(hv_qt), .LV_WINDOW_COMPARE_ON(lv_ws),
      .HV_WINDOW_COMPARE_ON(hv_ws), .LV_LOW_SIDE_SENSING(lv_ls), .LV_FIRST_TRIP(lv_ft),
      .LV_SECOND_TRIP(lv_st), .HV_FIRST_TRIP(hv_ft), .HV_SECOND_TRIP(hv_st));

   ////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // run length guard; nothing here waits on a handshake
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      $display("unexpected run length: expected end, seen none");
      wrap_up();
   end

   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk);
      #2;
      rst_b = 1'b1;
      for (int a = 8'h34; a <= 8'h37; a++) begin
         host_u.read(8'(a), rd);
         check("reset value", rd, 10'h000);
      end
      check("reset first trip", lv_ft, 10'h010);
      $display("test reset done");

      for (int a = 8'h34; a <= 8'h37; a++) begin
         host_u.write(8'(a), 8'hFF);
      end
      host_u.read(8'h34, rd);
      check("lv first byte", rd, 10'h0FC);
      check("hit mapped", reg_hit, 10'h001);
      host_u.read(8'h36, rd);
      check("hv first byte", rd, 10'h0F8);
      host_u.read(8'h35, rd);
      check("lv second byte", rd, 10'h0FF);
      check("lv quick level", lv_qt, 10'h007);
      check("hv quick level", hv_qt, 10'h007);
      check("lv window on", lv_ws, 10'h001);
      check("lv low side on", lv_ls, 10'h001);
      host_u.write(8'h34, 8'hE8);
      host_u.write(8'h36, 8'h04);
      check("lv low side off", lv_ls, 10'h000);
      check("lv window kept", lv_ws, 10'h001);
      check("hv window off", hv_ws, 10'h000);
      check("lv quick kept", lv_qt, 10'h007);
      check("hv quick cleared", hv_qt, 10'h000);
      host_u.read(8'h36, rd);
      check("hv unused bit", rd, 10'h000);
      host_u.write(8'h38, 8'h55);
      host_u.read(8'h38, rd);
      check("unmapped read", rd, 10'h000);
      check("hit unmapped", reg_hit, 10'h000);
      $display("test layout done");

      for (int gi = 0; gi < 4; gi++) begin
         for (int li = 0; li < 4; li++) begin
            g = 2'(gi);
            l = 2'(li);
            host_u.write(8'h35, {l, ~l, g, ~g});
            host_u.write(8'h37, {~l, l, ~g, g});
            check("lv first trip", lv_ft, trip_tbl[{g, l}]);
            check("lv second trip", lv_st, trip_tbl[{~g, ~l}]);
            check("hv first trip", hv_ft, trip_tbl[{~g, ~l}]);
            check("hv second trip", hv_st, trip_tbl[{g, l}]);
         end
      end
      $display("test trip decode done");

      host_u.write(8'h34, 8'h00);
      host_u.write(8'h36, 8'h00);
      lv_raw = 2'b11;
      hv_raw = 2'b01;
      @(posedge clk);
      #2;
      lv_raw = 2'b00;
      hv_raw = 2'b00;
      repeat (FD + 2) @(posedge clk);
      #2;
      check("lv short pulse", lv_cmp, 10'h000);
      check("hv short pulse", hv_cmp, 10'h000);
      lv_raw = 2'b11;
      hv_raw = 2'b10;
      repeat (FD - 1) @(posedge clk);
      #2;
      check("lv filter early", lv_cmp, 10'h000);
      repeat (2) @(posedge clk);
      #2;
      check("lv filtered", lv_cmp, 10'h003);
      check("hv filtered", hv_cmp, 10'h002);
      host_u.write(8'h34, 8'h10);
      host_u.write(8'h36, 8'h10);
      lv_raw = 2'b01;
      hv_raw = 2'b01;
      #1;
      check("lv bypass", lv_cmp, 10'h001);
      check("hv bypass", hv_cmp, 10'h001);
      $display("test deglitch done");

      @(posedge clk);
      #2;
      rst_b = 1'b0;
      @(posedge clk);
      #2;
      rst_b = 1'b1;
      check("reset lv cmp", lv_cmp, 10'h000);
      check("reset lv trip", lv_ft, 10'h010);
      check("reset lv window", lv_ws, 10'h000);
      host_u.read(8'h35, rd);
      check("reset lv second byte", rd, 10'h000);
      $display("test mid-run reset done");
      wrap_up();
   end
endmodule // current_monitor_config_tb
